//--- hw/bsm_branch_skip_unit.sv
// Execution unit for substitute, parity skip, index modify/skip and jumps
`timescale 1ns/10ps
`default_nettype none
// Operation
// RULE1: code 04 copies operand bits to lower accumulator under upper ones
// RULE2: code 05 does the same with operand at address field plus index
// RULE3: parity is the one-bit count of upper AND lower accumulator
// RULE4: 50 54 skips on odd parity, accumulators unchanged, skip takes 6 us
// RULE5: 50 55 skips on even parity, no-skip path takes 4.67 us
// RULE6: code 37 adds sign-extended address field to index, one's complement
// RULE7: code 56 skips if index equals operand, else index plus one
// RULE8: code 57 decrements nonzero operand in memory, skips when it is zero
// RULE9: all-ones operand counts nonzero and becomes all-ones minus one
// RULE10: loop jump decrements nonzero index and jumps; zero falls through
// RULE11: direct target is address field joined with top 3 bits of P
// RULE12: indirect jumps read one pointer word and use its low 15 bits
// RULE13: code 30 stores P plus one at pointer, then P gets pointer plus one
// RULE14: indirect call from entrance register stores P without increment
// RULE15: code 31 is code 30 with pointer at address field plus index
// RULE16: plain direct goto loads P with direct target, 4 us
// RULE17: indexed direct goto jumps to address field plus index, 8 us
// RULE18: unlocking indirect goto first clears interrupt lockout, then jumps
// RULE19: plain indirect goto loads P from pointer, no interrupt change
// RULE20: direct call stores zero-topped P plus one at target, jumps target+1
// RULE21: direct call from entrance register stores P unchanged
// RULE22: a met skip condition advances P by two
module bsm_branch_skip_unit
  import bsm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire bsm_req_type req,
  output logic busy,
  output logic done,
  output bsm_res_type result,
  output logic lockout_release,
  output bsm_mem_type mem,
  input wire logic mem_ack,
  input wire logic [17:0] mem_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  bsm_state_type state_q;
  bsm_state_type state_d;
  bsm_req_type inst_q;
  bsm_req_type inst_d;
  bsm_res_type res_q;
  bsm_res_type res_d;
  bsm_mem_type mem_q;
  bsm_mem_type mem_d;
  logic done_q;
  logic done_d;
  logic busy_q;
  logic busy_d;
  logic unlock_q;
  logic unlock_d;
  logic tmr_load;
  logic [11:0] tmr_value;
  logic tmr_expired;

  ////////////////////////////////////////////////////////////////////////////
  // Pacing timer
  bsm_exec_timer u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .load(tmr_load),
    .load_value(tmr_value),
    .expired(tmr_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [5:0] fc;
    logic [5:0] sub;
    logic [11:0] ufld;
    logic [14:0] dir_addr;
    logic [17:0] idx_sum;
    logic [14:0] idx_addr;
    logic parity_odd;
    logic [14:0] ret_addr;
    logic [14:0] ptr;
    logic [5:0] fc_q;
    fc = req.word[FC_LSB +: 6];
    sub = req.word[SUB_LSB +: 6];
    ufld = req.word[UFLD_W-1:0];
    dir_addr = {req.p[ADDR_W-1:BANK_LSB], ufld};                 // [RULE11]
    idx_sum = bsm_ones_add({6'h00, ufld}, req.b);
    idx_addr = idx_sum[ADDR_W-1:0];
    parity_odd = ^(req.al & req.au);                             // [RULE3]
    fc_q = inst_q.word[FC_LSB +: 6];
    ptr = mem_rdata[ADDR_W-1:0];                                 // [RULE12]
    ret_addr = inst_q.from_entrance ? inst_q.p :                 // [RULE14]
               inst_q.p + 15'h0001;                              // [RULE13]
    state_d = state_q;
    inst_d = inst_q;
    res_d = res_q;
    mem_d = mem_q;
    done_d = 1'b0;
    unlock_d = 1'b0;
    tmr_load = 1'b0;
    tmr_value = CYC_UNSUPPORTED;
    case (state_q)
      BSM_IDLE: begin
        if (start) begin
          inst_d = req;
          res_d.p = req.p + 15'h0001;
          res_d.al = req.al;
          res_d.b = req.b;
          res_d.unsupported = 1'b0;
          tmr_load = 1'b1;
          state_d = BSM_WAIT;
          case (fc)
            FC_MASKED_SUBSTITUTE: begin
              tmr_value = CYC_8US;                               // [RULE1]
              mem_d = '{req: 1'b1, we: 1'b0, addr: dir_addr, wdata: '0};
              state_d = BSM_READ;
            end
            FC_MASKED_SUBSTITUTE_INDEXED: begin
              tmr_value = CYC_12US;                              // [RULE2]
              mem_d = '{req: 1'b1, we: 1'b0, addr: idx_addr, wdata: '0};
              state_d = BSM_READ;
            end
            FC_INDEX_ADD_CONSTANT: begin
              tmr_value = CYC_12US;
              res_d.b = bsm_ones_add({{6{ufld[11]}}, ufld}, req.b); // [RULE6]
            end
            FC_INDEX_COMPARE_SKIP: begin
              tmr_value = CYC_16US;                              // [RULE7]
              mem_d = '{req: 1'b1, we: 1'b0, addr: dir_addr, wdata: '0};
              state_d = BSM_READ;
            end
            FC_MEMORY_COUNT_SKIP: begin
              tmr_value = CYC_12US;                              // [RULE8]
              mem_d = '{req: 1'b1, we: 1'b0, addr: dir_addr, wdata: '0};
              state_d = BSM_READ;
            end
            FC_INDEX_LOOP_JUMP: begin
              tmr_value = CYC_12US;
              if (req.b != WORD_RESET) begin                     // [RULE10]
                res_d.b = req.b - 18'h00001;
                res_d.p = dir_addr;
              end
            end
            FC_INDIRECT_CALL: begin
              tmr_value = CYC_12US;                              // [RULE13]
              mem_d = '{req: 1'b1, we: 1'b0, addr: dir_addr, wdata: '0};
              state_d = BSM_READ;
            end
            FC_INDIRECT_CALL_INDEXED: begin
              tmr_value = CYC_16US;                              // [RULE15]
              mem_d = '{req: 1'b1, we: 1'b0, addr: idx_addr, wdata: '0};
              state_d = BSM_READ;
            end
            FC_DIRECT_GOTO: begin
              tmr_value = CYC_4US;
              res_d.p = dir_addr;                                // [RULE16]
            end
            FC_DIRECT_GOTO_INDEXED: begin
              tmr_value = CYC_8US;
              res_d.p = idx_addr;                                // [RULE17]
            end
            FC_INDIRECT_GOTO_UNLOCK: begin
              tmr_value = CYC_4US;
              unlock_d = 1'b1;                                   // [RULE18]
              mem_d = '{req: 1'b1, we: 1'b0, addr: dir_addr, wdata: '0};
              state_d = BSM_READ;
            end
            FC_INDIRECT_GOTO: begin
              tmr_value = CYC_8US;                               // [RULE19]
              mem_d = '{req: 1'b1, we: 1'b0, addr: dir_addr, wdata: '0};
              state_d = BSM_READ;
            end
            FC_DIRECT_CALL: begin
              tmr_value = CYC_8US;
              mem_d = '{req: 1'b1, we: 1'b1, addr: dir_addr,
                        wdata: {3'b000, req.from_entrance ? req.p :
                                req.p + 15'h0001}};              // [RULE20]
              res_d.p = dir_addr + 15'h0001;                     // [RULE20]
              state_d = BSM_WRITE;
            end
            FC_SHIFT_GROUP: begin
              if (sub == SUB_SKIP_ON_ODD_PARITY) begin
                tmr_value = parity_odd ? CYC_6US : CYC_4US67;    // [RULE4]
                if (parity_odd) begin
                  res_d.p = req.p + 15'h0002;                    // [RULE22]
                end
              end else if (sub == SUB_SKIP_ON_EVEN_PARITY) begin
                tmr_value = parity_odd ? CYC_4US67 : CYC_6US;    // [RULE5]
                if (!parity_odd) begin
                  res_d.p = req.p + 15'h0002;                    // [RULE22]
                end
              end else begin
                res_d.unsupported = 1'b1;
              end
            end
            default: begin
              res_d.unsupported = 1'b1;
            end
          endcase
        end
      end
      BSM_READ: begin
        if (mem_ack) begin
          mem_d.req = 1'b0;
          state_d = BSM_WAIT;
          case (fc_q)
            FC_MASKED_SUBSTITUTE, FC_MASKED_SUBSTITUTE_INDEXED: begin
              res_d.al = (inst_q.al & ~inst_q.au) |
                         (mem_rdata & inst_q.au);                // [RULE1]
            end
            FC_INDEX_COMPARE_SKIP: begin
              if (mem_rdata == inst_q.b) begin                   // [RULE7]
                res_d.p = inst_q.p + 15'h0002;                   // [RULE22]
              end else begin
                res_d.b = bsm_ones_add(inst_q.b, 18'h00001);
              end
            end
            FC_MEMORY_COUNT_SKIP: begin
              if (mem_rdata == WORD_RESET) begin                 // [RULE8]
                res_d.p = inst_q.p + 15'h0002;                   // [RULE22]
              end else begin
                mem_d.req = 1'b1;
                mem_d.we = 1'b1;
                mem_d.wdata = mem_rdata - 18'h00001;             // [RULE9]
                state_d = BSM_WRITE;
              end
            end
            FC_INDIRECT_CALL, FC_INDIRECT_CALL_INDEXED: begin
              mem_d.req = 1'b1;
              mem_d.we = 1'b1;
              mem_d.addr = ptr;
              mem_d.wdata = {3'b000, ret_addr};                  // [RULE13]
              res_d.p = ptr + 15'h0001;                          // [RULE13]
              state_d = BSM_WRITE;
            end
            FC_INDIRECT_GOTO, FC_INDIRECT_GOTO_UNLOCK: begin
              res_d.p = ptr;                                     // [RULE19]
            end
            default: begin
              res_d.p = inst_q.p + 15'h0001;
            end
          endcase
        end
      end
      BSM_WRITE: begin
        if (mem_ack) begin
          mem_d.req = 1'b0;
          mem_d.we = 1'b0;
          state_d = BSM_WAIT;
        end
      end
      BSM_WAIT: begin
        // Done is raised only when the instruction time has run out; result already follows each step
        if (tmr_expired) begin
          done_d = 1'b1;
          state_d = BSM_IDLE;
        end
      end
      default: begin
        state_d = BSM_IDLE;
      end
    endcase
    busy_d = (state_d != BSM_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= BSM_IDLE;
      inst_q <= '0;
      res_q <= '{p: ADDR_RESET, al: WORD_RESET, b: WORD_RESET,
                 unsupported: 1'b0};
      mem_q <= '{req: 1'b0, we: 1'b0, addr: ADDR_RESET, wdata: WORD_RESET};
      done_q <= 1'b0;
      busy_q <= 1'b0;
      unlock_q <= 1'b0;
    end else begin
      state_q <= state_d;
      inst_q <= inst_d;
      res_q <= res_d;
      mem_q <= mem_d;
      done_q <= done_d;
      busy_q <= busy_d;
      unlock_q <= unlock_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign result = res_q;
  assign lockout_release = unlock_q;
  assign mem = mem_q;

endmodule
`default_nettype wire

//--- hw/bsm_exec_timer.sv
// Down-counter that paces each instruction to its execution time
`timescale 1ns/10ps
`default_nettype none
module bsm_exec_timer (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [11:0] load_value,
  output logic expired
);

  logic [11:0] cnt_q;
  logic [11:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_value - 12'h001;
    end else if (cnt_q != 12'h000) begin
      cnt_d = cnt_q - 12'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= 12'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign expired = (cnt_q == 12'h000) && !load;

endmodule
`default_nettype wire

//--- hw/bsm_pkg.sv
// Package: opcodes, timing counts and carrier structs for the branch/skip unit
package bsm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Word layout
  localparam int WORD_W = 18;
  localparam int ADDR_W = 15;
  localparam int UFLD_W = 12;
  localparam int FC_LSB = 12;
  localparam int SUB_LSB = 6;
  localparam int BANK_LSB = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Function codes (octal value in the comment)
  localparam logic [5:0] FC_MASKED_SUBSTITUTE = 6'h04;         // 04
  localparam logic [5:0] FC_MASKED_SUBSTITUTE_INDEXED = 6'h05; // 05
  localparam logic [5:0] FC_INDIRECT_CALL = 6'h18;             // 30
  localparam logic [5:0] FC_INDIRECT_CALL_INDEXED = 6'h19;     // 31
  localparam logic [5:0] FC_INDIRECT_GOTO_UNLOCK = 6'h1a;      // 32
  localparam logic [5:0] FC_INDIRECT_GOTO = 6'h1b;             // 33
  localparam logic [5:0] FC_DIRECT_GOTO = 6'h1c;               // 34
  localparam logic [5:0] FC_DIRECT_GOTO_INDEXED = 6'h1d;       // 35
  localparam logic [5:0] FC_DIRECT_CALL = 6'h1e;               // 36
  localparam logic [5:0] FC_INDEX_ADD_CONSTANT = 6'h1f;        // 37
  localparam logic [5:0] FC_INDEX_LOOP_JUMP = 6'h20;           // 40
  localparam logic [5:0] FC_SHIFT_GROUP = 6'h28;               // 50
  localparam logic [5:0] FC_INDEX_COMPARE_SKIP = 6'h2e;        // 56
  localparam logic [5:0] FC_MEMORY_COUNT_SKIP = 6'h2f;         // 57
  localparam logic [5:0] SUB_SKIP_ON_ODD_PARITY = 6'h2c;       // 54
  localparam logic [5:0] SUB_SKIP_ON_EVEN_PARITY = 6'h2d;      // 55

  ////////////////////////////////////////////////////////////////////////////
  // Execution times
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_4US_NS = 4000;
  localparam int T_4US67_NS = 4670;
  localparam int T_6US_NS = 6000;
  localparam int T_8US_NS = 8000;
  localparam int T_12US_NS = 12000;
  localparam int T_16US_NS = 16000;
  localparam logic [11:0] CYC_4US =
    12'((T_4US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CYC_4US67 =
    12'((T_4US67_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CYC_6US =
    12'((T_6US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CYC_8US =
    12'((T_8US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CYC_12US =
    12'((T_12US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CYC_16US =
    12'((T_16US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CYC_UNSUPPORTED = 12'h001;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [17:0] WORD_RESET = 18'h00000;
  localparam logic [14:0] ADDR_RESET = 15'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [17:0] word;
    logic [14:0] p;
    logic [17:0] au;
    logic [17:0] al;
    logic [17:0] b;
    logic from_entrance;
  } bsm_req_type;

  typedef struct packed {
    logic [14:0] p;
    logic [17:0] al;
    logic [17:0] b;
    logic unsupported;
  } bsm_res_type;

  typedef struct packed {
    logic req;
    logic we;
    logic [14:0] addr;
    logic [17:0] wdata;
  } bsm_mem_type;

  typedef enum logic [1:0] {
    BSM_IDLE = 2'b00,
    BSM_READ = 2'b01,
    BSM_WRITE = 2'b10,
    BSM_WAIT = 2'b11
  } bsm_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // One's complement add with end-around carry
  function automatic logic [17:0] bsm_ones_add(input logic [17:0] a,
                                               input logic [17:0] b);
    logic [18:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[17:0] + {17'h00000, s[18]};
  endfunction

endpackage

//--- sim/bsm_branch_skip_unit_monitor.sv
// Port checker for the branch/skip unit, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module bsm_branch_skip_unit_monitor
  import bsm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire bsm_req_type req,
  input wire logic busy,
  input wire logic done,
  input wire bsm_res_type result,
  input wire logic lockout_release,
  input wire bsm_mem_type mem,
  input wire logic mem_ack,
  input wire logic [17:0] mem_rdata
);
  ////////////////////////////////////////////////////////////////////////////
  // Request captured at the taking edge, cycles counted from it
  bsm_req_type cap_q, cap_d;
  logic [11:0] cnt_q, cnt_d;
  logic [5:0] fc;
  logic par;
  logic skip;

  always_comb begin
    cap_d = cap_q;
    cnt_d = cnt_q + 12'h001;
    // Zero at the taking edge, so done arrives with the cycle count
    if (start && !busy) begin
      cap_d = req;
      cnt_d = 12'h000;
    end
  end

  always_ff @(posedge core_clk) begin
    cap_q <= rst ? '0 : cap_d;
    cnt_q <= rst ? 12'h000 : cnt_d;
  end

  assign fc = cap_q.word[17:12];
  assign par = fc == FC_SHIFT_GROUP && cap_q.word[11:7] == 5'h16;
  assign skip = (^(cap_q.au & cap_q.al)) ^ cap_q.word[6];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_GOTO_TARGET: assert property (
    done && fc == FC_DIRECT_GOTO |->
    result.p == {cap_q.p[14:12], cap_q.word[11:0]})
    else $error("direct goto target wrong");
  AST_GOTO_TIME: assert property (done && fc == FC_DIRECT_GOTO |->
    cnt_q == 12'd800) else $error("direct goto time wrong");
  AST_PARITY_TIME: assert property (done && par |->
    cnt_q == (skip ? 12'd1200 : 12'd934)) else $error("parity time wrong");
  AST_PARITY_PC: assert property (done && par |->
    result.p == cap_q.p + (skip ? 15'h0002 : 15'h0001) &&
    result.al == cap_q.al) else $error("parity skip result wrong");
  AST_UNLOCK_PULSE: assert property (start && !busy &&
    req.word[17:12] == FC_INDIRECT_GOTO_UNLOCK |=>
    lockout_release ##1 !lockout_release) else $error("no lockout release");
  AST_UNLOCK_ONLY: assert property (lockout_release |->
    fc == FC_INDIRECT_GOTO_UNLOCK && cnt_q == 12'h000)
    else $error("stray lockout release");
  AST_MEM_HOLD: assert property (mem.req && !mem_ack |=>
    mem.req && $stable(mem)) else $error("memory request not held");
  AST_LOOP: assert property (done && fc == FC_INDEX_LOOP_JUMP |->
    (cap_q.b == 18'h00000) ?
    (result.b == 18'h00000 && result.p == cap_q.p + 15'h0001) :
    (result.b == cap_q.b - 18'h00001 &&
    result.p == {cap_q.p[14:12], cap_q.word[11:0]}))
    else $error("loop jump result wrong");

  COV_GOTO: cover property (done && fc == FC_DIRECT_GOTO);
  COV_SKIP: cover property (done && par && skip);
  COV_UNLOCK: cover property (lockout_release);
  COV_WRITE: cover property (mem.req && mem.we && mem_ack);
endmodule

bind bsm_branch_skip_unit bsm_branch_skip_unit_monitor u_mon (
  .core_clk(core_clk),
  .rst(rst),
  .start(start),
  .req(req),
  .busy(busy),
  .done(done),
  .result(result),
  .lockout_release(lockout_release),
  .mem(mem),
  .mem_ack(mem_ack),
  .mem_rdata(mem_rdata)
);
`default_nettype wire

//--- sim/bsm_branch_skip_unit_tb_top.sv
// Self-checking bench for the branch/skip unit
`timescale 1ns/10ps
`default_nettype none
module bsm_branch_skip_unit_tb_top;
  import bsm_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic slow = 1'b0;
  logic dup = 1'b0;
  logic busy, done, lockout_release, mem_ack;
  logic [17:0] mem_rdata;
  logic [31:0] lfsr = 32'h00000038;
  bsm_req_type req = '0;
  bsm_res_type result;
  bsm_mem_type mem;
  int n_fail = 0;
  int total_checks = 0;

  always #2.5 core_clk = ~core_clk;

  bsm_branch_skip_unit dut (.core_clk(core_clk), .rst(rst), .start(start),
    .req(req), .busy(busy), .done(done), .result(result),
    .lockout_release(lockout_release), .mem(mem), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  bsm_core_mem_model u_mem (.core_clk(core_clk), .rst(rst), .slow(slow),
    .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [17:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[17:0];
  endfunction

  function automatic int oadd(int a, int c);
    int s;
    s = a + c;
    return (s > 32'h3ffff) ? (s & 32'h3ffff) + 1 : s;
  endfunction

  function automatic bsm_req_type mk(logic [5:0] fc, logic fe);
    bsm_req_type r;
    logic [17:0] t;
    t = rnd();
    r.word = {fc, t[11:0]};
    t = rnd();
    r.p = t[14:0];
    r.au = rnd();
    r.al = rnd();
    r.b = rnd();
    r.from_entrance = fe;
    return r;
  endfunction

  task automatic check(string what, logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s at %0t: got %h exp %h", what, $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One instruction against the reference model
  task automatic run(bsm_req_type r, logic [17:0] y);
    int dir, idx, ep, eal, eb, ec, wa, wv, sk, un, n, lk, sx;
    logic [5:0] fc;
    fc = r.word[17:12];
    dir = {r.p[14:12], r.word[11:0]};
    idx = oadd(r.word[11:0], r.b) & 32'h7fff;
    u_mem.words[dir] = y;
    u_mem.words[idx] = y;
    ep = (r.p + 1) & 32'h7fff;
    eal = r.al;
    eb = r.b;
    wa = -1;
    wv = r.from_entrance ? r.p : ep;
    sk = 0;
    un = 0;
    case (fc)
      FC_MASKED_SUBSTITUTE, FC_MASKED_SUBSTITUTE_INDEXED: begin
        eal = (r.al & ~r.au) | (y & r.au);
        ec = (fc == FC_MASKED_SUBSTITUTE) ? 1600 : 2400;
      end
      FC_SHIFT_GROUP: begin
        sk = (^(r.au & r.al)) ^ r.word[6];
        ec = sk ? 1200 : 934;
      end
      FC_INDEX_ADD_CONSTANT: begin
        sx = r.word[11] ? 32'h0003f000 : 32'h00000000;
        eb = oadd(r.b, sx | r.word[11:0]);
        ec = 2400;
      end
      FC_INDEX_COMPARE_SKIP: begin
        sk = (r.b == y);
        eb = sk ? r.b : oadd(r.b, 1);
        ec = 3200;
      end
      FC_MEMORY_COUNT_SKIP: begin
        sk = (y == 18'h00000);
        wa = sk ? -1 : dir;
        wv = y - 1;
        ec = 2400;
      end
      FC_INDEX_LOOP_JUMP: begin
        eb = (r.b != 0) ? r.b - 1 : r.b;
        ep = (r.b != 0) ? dir : ep;
        ec = 2400;
      end
      FC_DIRECT_GOTO: begin
        ep = dir;
        ec = 800;
      end
      FC_DIRECT_GOTO_INDEXED: begin
        ep = idx;
        ec = 1600;
      end
      FC_INDIRECT_GOTO_UNLOCK, FC_INDIRECT_GOTO: begin
        ep = y & 32'h7fff;
        ec = (fc == FC_INDIRECT_GOTO) ? 1600 : 800;
      end
      FC_INDIRECT_CALL, FC_INDIRECT_CALL_INDEXED, FC_DIRECT_CALL: begin
        wa = (fc == FC_DIRECT_CALL) ? dir : y & 32'h7fff;
        ep = (wa + 1) & 32'h7fff;
        ec = (fc == FC_INDIRECT_CALL_INDEXED) ? 3200 : 2400;
        ec = (fc == FC_DIRECT_CALL) ? 1600 : ec;
      end
      default: begin
        un = 1;
        ec = 1;
      end
    endcase
    ep = sk ? (r.p + 2) & 32'h7fff : ep;
    // Let an edge pass so start is not lowered and raised in one step
    @(negedge core_clk);
    req = r;
    start = 1'b1;
    n = 0;
    lk = 0;
    do begin
      @(negedge core_clk);
      n++;
      start = dup && n == 5;
      if (n == 5) req.word = 18'h00000;
      if (lockout_release === 1'b1) lk++;
    end while (done !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      n_fail++;
      print_verdict();
    end else begin
      check("p", result.p, ep);
      check("al", result.al, eal);
      check("b", result.b, eb);
      check("unsupported", result.unsupported, un);
      // n counts from the negedge after the taking edge
      if (!slow) check("cycles", n - 1, ec);
      check("lockout", lk, fc == FC_INDIRECT_GOTO_UNLOCK);
      if (wa >= 0) check("written", u_mem.words[wa], wv);
      if (fc == FC_MEMORY_COUNT_SKIP && sk) begin
        check("kept", u_mem.words[dir], y);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    bsm_req_type r;
    logic [5:0] fcs [16];
    fcs = '{6'h04, 6'h05, 6'h28, 6'h1f, 6'h2e, 6'h2f,
      6'h20, 6'h1c, 6'h1d, 6'h1a, 6'h1b, 6'h18, 6'h19, 6'h1e, 6'h01, 6'h3f};
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    for (int i = 0; i < 32; i++) begin
      slow = i[0];
      dup = i[1];
      r = mk(fcs[i % 16], i[4]);
      if (r.word[17:12] == FC_SHIFT_GROUP) r.word[11:6] = {5'h16, i[4]};
      run(r, rnd());
    end
    slow = 1'b0;
    dup = 1'b0;
    r = mk(FC_MEMORY_COUNT_SKIP, 1'b0);
    run(r, 18'h00000);
    run(r, 18'h3ffff);
    r = mk(FC_INDEX_LOOP_JUMP, 1'b0);
    r.b = 18'h00000;
    run(r, rnd());
    r.b = 18'h3ffff;
    run(r, rnd());
    r = mk(FC_INDEX_COMPARE_SKIP, 1'b0);
    run(r, r.b);
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    check("reset", {busy, done, mem.req, lockout_release}, 0);
    @(negedge core_clk);
    run(mk(FC_DIRECT_GOTO, 1'b0), rnd());
    print_verdict();
  end
endmodule
`default_nettype wire

//--- sim/bsm_core_mem_model.sv
// Behavioural core memory answering the unit's word accesses
`timescale 1ns/10ps
`default_nettype none
module bsm_core_mem_model
  import bsm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow,
  input wire bsm_mem_type mem,
  output logic mem_ack,
  output logic [17:0] mem_rdata
);
  logic [17:0] words [0:32767];
  logic [1:0] wait_q;

  // Read data is only valid in the ack cycle of a read; it toggles otherwise, write acks included
  always @(posedge core_clk) begin
    if (rst) begin
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
      mem_rdata <= 18'h15555;
    end else if (mem.req && !mem_ack && (!slow || wait_q == 2'h3)) begin
      mem_ack <= 1'b1;
      wait_q <= 2'h0;
      mem_rdata <= mem.we ? ~mem_rdata : words[mem.addr];
      if (mem.we) begin
        words[mem.addr] <= mem.wdata;
      end
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem.req && !mem_ack) begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire
